// file: bcd_consts.svh
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

// ----------------------------------------------------------------
// interface command codes, 7-bit
// ----------------------------------------------------------------
`define BCD_CMD_GO_LOCAL     7'h01
`define BCD_CMD_SEL_CLEAR    7'h04
`define BCD_CMD_GROUP_TRIG   7'h08
`define BCD_CMD_LOCKOUT      7'h11
`define BCD_CMD_DEV_CLEAR    7'h14
`define BCD_CMD_UNLISTEN     7'h3f
`define BCD_CMD_UNTALK       7'h5f

// ----------------------------------------------------------------
// address groups: code[6:5] selects group, code[4:0] the address
// ----------------------------------------------------------------
`define BCD_GRP_MSB          6
`define BCD_GRP_LSB          5
`define BCD_ADDR_MSB         4
`define BCD_GRP_LISTEN       2'h1
`define BCD_GRP_TALK         2'h2

// ----------------------------------------------------------------
// pin vector layout after synchronising
// ----------------------------------------------------------------
`define BCD_PIN_W            12
`define BCD_PIN_REN          0
`define BCD_PIN_IFC          1
`define BCD_PIN_ATN          2
`define BCD_PIN_DAV          3
`define BCD_PIN_DIO_LSB      4
`define BCD_PIN_RST_VAL      12'hfff

`endif

// file: bcd_pkg.sv
package bcd_pkg;

  typedef enum logic [0:0] {
    BCD_ST_IDLE   = 1'b0,
    BCD_ST_ACCEPT = 1'b1
  } bcd_hs_state_e;

  typedef logic [7:0] bcd_byte_t;

endpackage : bcd_pkg

// file: bcd_decoder.sv
`timescale 1ns/100ps
`include "bcd_consts.svh"

module bcd_decoder (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] dio_n_pin,
  input  wire logic       dav_n_pin,
  input  wire logic       atn_n_pin,
  input  wire logic       ifc_n_pin,
  input  wire logic       ren_n_pin,
  output logic            nrfd_n_o,
  output logic            nrfd_oe,
  output logic            ndac_n_o,
  output logic            ndac_oe,
  input  wire logic [4:0] primary_addr,
  input  wire logic       parser_ready,
  output logic [7:0]      parser_data,
  output logic            parser_valid,
  output logic            listen_q,
  output logic            talk_q,
  output logic            talk_en,
  output logic            remote_q,
  output logic            lockout_q,
  output logic            trigger_q,
  output logic            dev_clear_q
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`BCD_PIN_W-1:0] pin_raw;
  logic [`BCD_PIN_W-1:0] sync1_q;
  logic [`BCD_PIN_W-1:0] sync2_q;
  logic [`BCD_PIN_W-1:0] sync3_q;
  logic [`BCD_PIN_W-1:0] pin_q;

  assign pin_raw = {dio_n_pin, dav_n_pin, atn_n_pin, ifc_n_pin, ren_n_pin};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= `BCD_PIN_RST_VAL;
      sync2_q <= `BCD_PIN_RST_VAL;
      sync3_q <= `BCD_PIN_RST_VAL;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a change counts only once two stages agree, filtering one-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < `BCD_PIN_W; gi = gi + 1) begin : g_filt
      always_ff @(posedge clk) begin
        if (rst) begin
          pin_q[gi] <= 1'b1;
        end else if (sync2_q[gi] == sync3_q[gi]) begin
          pin_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  // bus lines are low-true
  logic            ren;
  logic            ifc;
  logic            atn;
  logic            dav;
  bcd_pkg::bcd_byte_t dio;
  logic            ren_prev_q;

  assign ren = ~pin_q[`BCD_PIN_REN];
  assign ifc = ~pin_q[`BCD_PIN_IFC];
  assign atn = ~pin_q[`BCD_PIN_ATN];
  assign dav = ~pin_q[`BCD_PIN_DAV];
  assign dio = ~pin_q[`BCD_PIN_W-1:`BCD_PIN_DIO_LSB];

  always_ff @(posedge clk) begin
    if (rst) begin
      ren_prev_q <= 1'b0;
    end else begin
      ren_prev_q <= ren;
    end
  end

  // ----------------------------------------------------------------
  // acceptor handshake
  // ----------------------------------------------------------------
  bcd_pkg::bcd_hs_state_e hs_q;
  logic participate;
  logic ready_now;
  logic take;

  // unaddressed during data, the device stays off the handshake lines
  assign participate = atn | listen_q;
  // parser back-pressure holds ready-for-data false on data bytes only
  assign ready_now = participate & (atn | parser_ready);
  assign take = (hs_q == bcd_pkg::BCD_ST_IDLE) & ready_now & dav & ~ifc;

  always_ff @(posedge clk) begin
    if (rst) begin
      hs_q <= bcd_pkg::BCD_ST_IDLE;
    end else begin
      unique case (hs_q)
        bcd_pkg::BCD_ST_IDLE: begin
          if (take) begin
            hs_q <= bcd_pkg::BCD_ST_ACCEPT;
          end
        end
        bcd_pkg::BCD_ST_ACCEPT: begin
          if (!dav) begin
            hs_q <= bcd_pkg::BCD_ST_IDLE;
          end
        end
      endcase
    end
  end

  // open-drain: only ever pull low
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;
  assign nrfd_oe  = (hs_q == bcd_pkg::BCD_ST_ACCEPT) | (participate & ~ready_now);
  assign ndac_oe  = (hs_q == bcd_pkg::BCD_ST_IDLE) & participate;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic logic is_code(input bcd_pkg::bcd_byte_t b, input logic [6:0] code);
    is_code = (b[6:0] == code);
  endfunction : is_code

  function automatic logic is_grp(input bcd_pkg::bcd_byte_t b, input logic [1:0] grp);
    is_grp = (b[`BCD_GRP_MSB:`BCD_GRP_LSB] == grp);
  endfunction : is_grp

  logic cmd;
  logic own_addr;
  logic c_unl;
  logic c_unt;
  logic c_lag;
  logic c_tag;

  assign cmd      = take & atn;
  assign own_addr = (dio[`BCD_ADDR_MSB:0] == primary_addr);
  assign c_unl    = cmd & is_code(dio, `BCD_CMD_UNLISTEN);
  assign c_unt    = cmd & is_code(dio, `BCD_CMD_UNTALK);
  // all-ones address is unlisten or untalk, never an own address
  assign c_lag    = cmd & is_grp(dio, `BCD_GRP_LISTEN) & ~c_unl;
  assign c_tag    = cmd & is_grp(dio, `BCD_GRP_TALK) & ~c_unt;

  logic c_gtl;
  logic c_sdc;
  logic c_get;
  logic c_llo;
  logic c_dcl;

  assign c_gtl = cmd & listen_q & is_code(dio, `BCD_CMD_GO_LOCAL);
  assign c_sdc = cmd & listen_q & is_code(dio, `BCD_CMD_SEL_CLEAR);
  assign c_get = cmd & listen_q & is_code(dio, `BCD_CMD_GROUP_TRIG);
  assign c_llo = cmd & is_code(dio, `BCD_CMD_LOCKOUT);
  assign c_dcl = cmd & is_code(dio, `BCD_CMD_DEV_CLEAR);

  // ----------------------------------------------------------------
  // addressing state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || ifc) begin
      listen_q <= 1'b0;
    end else if (c_unl) begin
      listen_q <= 1'b0;
    end else if (c_lag && own_addr) begin
      listen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ifc) begin
      talk_q <= 1'b0;
    end else if (c_unt) begin
      talk_q <= 1'b0;
    end else if (c_tag) begin
      // another talker's address takes the bus from us
      talk_q <= own_addr;
    end
  end

  // no driving while attention is true or talk address absent
  assign talk_en = talk_q & ~atn;

  // ----------------------------------------------------------------
  // remote and lockout
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || ifc || !ren) begin
      remote_q <= 1'b0;
    end else if (c_gtl) begin
      remote_q <= 1'b0;
    end else if (ren && !ren_prev_q) begin
      remote_q <= 1'b1;
    end else if (c_lag && own_addr) begin
      remote_q <= 1'b1;
    end
  end

  // lockout drops with reset, interface clear, remote enable false or go-to-local while addressed to listen
  always_ff @(posedge clk) begin
    if (rst || ifc || !ren) begin
      lockout_q <= 1'b0;
    end else if (c_gtl) begin
      lockout_q <= 1'b0;
    end else if (c_llo) begin
      lockout_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // event pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      trigger_q   <= 1'b0;
      dev_clear_q <= 1'b0;
    end else begin
      trigger_q   <= c_get;
      dev_clear_q <= c_sdc | c_dcl;
    end
  end

  // ----------------------------------------------------------------
  // device-dependent data to parser
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      parser_data  <= 8'h00;
      parser_valid <= 1'b0;
    end else begin
      parser_valid <= take & ~atn & listen_q;
      if (take && !atn && listen_q) begin
        parser_data <= dio;
      end
    end
  end

endmodule : bcd_decoder

// file: bcd_sva.sv
`timescale 1ns/100ps
module bcd_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ifc_n_pin,
  input wire logic       ren_n_pin,
  input wire logic       nrfd_oe,
  input wire logic       ndac_oe,
  input wire logic [7:0] parser_data,
  input wire logic       parser_valid,
  input wire logic       listen_q,
  input wire logic       talk_q,
  input wire logic       talk_en,
  input wire logic       remote_q,
  input wire logic       lockout_q,
  input wire logic       trigger_q,
  input wire logic       dev_clear_q
);
  // ----------------------------------------------------------------
  // pin-side rules allow 8 edges for the synchroniser and filter
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_idle: assert property (disable iff (1'b0) rst |=> !(listen_q || talk_q || remote_q || lockout_q))
    else $error("not idle after reset");
  a_ifc_idle: assert property (!ifc_n_pin [*8] |=> !listen_q && !talk_q) else $error("ifc kept address");
  a_ren_local: assert property (ren_n_pin [*8] |=> !remote_q && !lockout_q) else $error("remote without ren");
  a_talk_gate: assert property (talk_en |-> talk_q) else $error("talk drive without address");
  a_trig_listen: assert property (trigger_q |-> listen_q && nrfd_oe && !ndac_oe) else $error("bad trigger");
  a_trig_pulse: assert property (trigger_q |=> !trigger_q) else $error("trigger too long");
  a_clear_pulse: assert property (dev_clear_q |=> !dev_clear_q) else $error("clear too long");
  a_data_listen: assert property (parser_valid |-> listen_q && nrfd_oe && !ndac_oe) else $error("bad data");
  a_data_hold: assert property (!parser_valid |-> $stable(parser_data)) else $error("data moved");
endmodule : bcd_sva

bind bcd_decoder bcd_sva chk_u (.clk, .rst, .ifc_n_pin, .ren_n_pin, .nrfd_oe, .ndac_oe, .parser_data,
  .parser_valid, .listen_q, .talk_q, .talk_en, .remote_q, .lockout_q, .trigger_q, .dev_clear_q);

// file: bcd_ctrl_model.sv
`timescale 1ns/100ps
module bcd_ctrl_model (
  input  wire logic       clk,
  input  wire logic       nrfd_oe,
  input  wire logic       ndac_oe,
  output logic [7:0]      dio_n_pin,
  output logic            dav_n_pin,
  output logic            atn_n_pin,
  output logic            ifc_n_pin,
  output logic            ren_n_pin
);
  // released lines float high through the terminations
  initial begin
    dio_n_pin = 8'hff;
    dav_n_pin = 1'b1;
    atn_n_pin = 1'b1;
    ifc_n_pin = 1'b1;
    ren_n_pin = 1'b1;
  end

  // ----------------------------------------------------------------
  // source handshake; a silent device only costs the bounded wait
  // ----------------------------------------------------------------
  task automatic xfer(input logic atn_true, input logic [7:0] b);
    int n;
    @(negedge clk);
    atn_n_pin = !atn_true;
    dio_n_pin = ~b;
    // acceptors need time to see a new attention state before their lines mean anything
    repeat (25) @(negedge clk);
    n = 0;
    while ((nrfd_oe || !ndac_oe) && n < 300) begin
      @(negedge clk);
      n++;
    end
    dav_n_pin = 1'b0;
    n = 0;
    @(negedge clk);
    while (ndac_oe && n < 300) begin
      @(negedge clk);
      n++;
    end
    dav_n_pin = 1'b1;
    dio_n_pin = 8'hff;
    repeat (2) @(negedge clk);
  endtask : xfer

  task automatic atn_off;
    @(negedge clk);
    atn_n_pin = 1'b1;
  endtask : atn_off

  task automatic lines(input logic ifc_true, input logic ren_true);
    @(negedge clk);
    ifc_n_pin = !ifc_true;
    ren_n_pin = !ren_true;
  endtask : lines
endmodule : bcd_ctrl_model

// file: bcd_tb.sv
`timescale 1ns/100ps
module tb;
  logic       clk, rst, parser_ready, dav_n_pin, atn_n_pin, ifc_n_pin, ren_n_pin, nrfd_oe, ndac_oe;
  logic       parser_valid, listen_q, talk_q, talk_en, remote_q, lockout_q, trigger_q, dev_clear_q;
  logic       nrfd_n_o, ndac_n_o;
  logic [4:0] primary_addr;
  logic [7:0] dio_n_pin, parser_data, last_data;
  int         fails, checks_done, cyc, trig_n, clr_n, data_n;

  bcd_decoder dut_u (
    .clk          (clk),
    .rst          (rst),
    .dio_n_pin    (dio_n_pin),
    .dav_n_pin    (dav_n_pin),
    .atn_n_pin    (atn_n_pin),
    .ifc_n_pin    (ifc_n_pin),
    .ren_n_pin    (ren_n_pin),
    .nrfd_n_o     (nrfd_n_o),
    .nrfd_oe      (nrfd_oe),
    .ndac_n_o     (ndac_n_o),
    .ndac_oe      (ndac_oe),
    .primary_addr (primary_addr),
    .parser_ready (parser_ready),
    .parser_data  (parser_data),
    .parser_valid (parser_valid),
    .listen_q     (listen_q),
    .talk_q       (talk_q),
    .talk_en      (talk_en),
    .remote_q     (remote_q),
    .lockout_q    (lockout_q),
    .trigger_q    (trigger_q),
    .dev_clear_q  (dev_clear_q)
  );
  bcd_ctrl_model ctrl_u (.clk, .nrfd_oe, .ndac_oe, .dio_n_pin, .dav_n_pin, .atn_n_pin, .ifc_n_pin, .ren_n_pin);

  always #2 clk = ~clk;

  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_n(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      fails++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n

  // packed as listen, talk, remote, lockout
  task automatic chk_st(input logic [3:0] exp);
    chk("state", {4'h0, exp}, {4'h0, listen_q, talk_q, remote_q, lockout_q});
  endtask : chk_st

  // pulses are one cycle wide, so count them as they pass
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
    if (trigger_q === 1'b1) trig_n++;
    if (dev_clear_q === 1'b1) clr_n++;
    if (parser_valid === 1'b1) begin
      data_n++;
      last_data = parser_data;
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    parser_ready = 1'b1;
    primary_addr = 5'h10;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk_st(4'h0);
    ctrl_u.xfer(1'b0, 8'h46);
    chk_n("data unaddressed", 0, data_n);
    ctrl_u.lines(1'b0, 1'b1);
    repeat (8) @(negedge clk);
    chk_st(4'h2);
    ctrl_u.xfer(1'b1, 8'h3f);
    ctrl_u.xfer(1'b1, 8'h30);
    chk_st(4'ha);
    parser_ready = 1'b0;
    fork
      ctrl_u.xfer(1'b0, 8'h46);
      begin
        repeat (40) @(negedge clk);
        chk_n("data stalled", 0, data_n);
        parser_ready = 1'b1;
      end
    join
    ctrl_u.xfer(1'b0, 8'h3f);
    ctrl_u.xfer(1'b0, 8'h58);
    chk_n("data count", 3, data_n);
    chk("last data", 8'h58, last_data);
    chk_st(4'ha);
    ctrl_u.xfer(1'b1, 8'h88);
    chk_n("trigger", 1, trig_n);
    ctrl_u.xfer(1'b1, 8'h84);
    chk_n("sel clear", 1, clr_n);
    ctrl_u.xfer(1'b1, 8'h11);
    chk_st(4'hb);
    ctrl_u.xfer(1'b1, 8'h01);
    chk_st(4'h8);
    ctrl_u.xfer(1'b1, 8'h3f);
    chk_st(4'h0);
    ctrl_u.xfer(1'b1, 8'h08);
    ctrl_u.xfer(1'b1, 8'h04);
    chk_n("unaddressed", 2, trig_n + clr_n);
    ctrl_u.xfer(1'b1, 8'h94);
    chk_n("dev clear", 2, clr_n);
    ctrl_u.xfer(1'b1, 8'h11);
    chk("lockout", 8'h1, 8'(lockout_q));
    ctrl_u.xfer(1'b1, 8'h01);
    chk("lockout kept", 8'h1, 8'(lockout_q));
    ctrl_u.xfer(1'b1, 8'h50);
    chk("talk", 8'h1, 8'(talk_q));
    chk("talk drive", 8'h0, 8'(talk_en));
    ctrl_u.atn_off();
    repeat (8) @(negedge clk);
    chk("talk drive", 8'h1, 8'(talk_en));
    ctrl_u.xfer(1'b1, 8'h45);
    chk("other talker", 8'h0, 8'(talk_q));
    ctrl_u.xfer(1'b1, 8'h50);
    chk("talk again", 8'h1, 8'(talk_q));
    ctrl_u.xfer(1'b1, 8'h5f);
    chk("talk", 8'h0, 8'(talk_q));
    primary_addr = 5'h00;
    ctrl_u.xfer(1'b1, 8'ha0);
    chk("listen", 8'h1, 8'(listen_q));
    ctrl_u.lines(1'b1, 1'b1);
    repeat (10) @(negedge clk);
    ctrl_u.lines(1'b0, 1'b0);
    repeat (10) @(negedge clk);
    chk_st(4'h0);
    chk("open drain", 8'h00, {6'h00, nrfd_n_o, ndac_n_o});
    tally_and_finish();
  end
endmodule : tb
